// >>> clk_cfg_pkg.sv
// Constants shared by the clock divider configuration logic
package clk_cfg_pkg;

    localparam int unsigned MCLK_MHZ = 250;
    localparam int unsigned REF_MHZ = 25;
    localparam int unsigned PRESCALE = 1;
    localparam int unsigned STRAP_SETTLE_CYC = 3;

    localparam int unsigned FB_W = 11;
    localparam int unsigned OUT_W = 7;
    localparam int unsigned STRAP_W = 4;
    localparam int unsigned REF_OUTS = 2;
    localparam int unsigned DDR_OUTS = 4;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] FB_DIV_OFS = 8'h04;
    localparam logic [7:0] OUT_DIV_OFS = 8'h08;
    localparam logic [7:0] OUT_DIS_OFS = 8'h0C;
    localparam logic [7:0] STATUS_OFS = 8'h10;

    // Field positions
    localparam int unsigned CTRL_MARGIN_BIT = 0;
    localparam int unsigned CTRL_SPREAD_BIT = 1;
    localparam int unsigned SYS_DIV_LSB = 0;
    localparam int unsigned DDR_DIV_LSB = 8;
    localparam int unsigned REF_DIS_LSB = 0;
    localparam int unsigned DDR_DIS_LSB = 2;
    localparam int unsigned ST_STRAP_LSB = 0;
    localparam int unsigned ST_REF_EN_LSB = 4;
    localparam int unsigned ST_DDR_EN_LSB = 6;
    localparam int unsigned ST_MARGIN_ACT_BIT = 10;

    // Strap-derived defaults: VCO at 25 MHz times 80, feedback fixed, output divider per choice
    localparam logic [FB_W-1:0] FB_DIV_DEF = 11'h050;
    localparam logic [OUT_W-1:0] DIV_66M = 7'h1E;
    localparam logic [OUT_W-1:0] DIV_100M = 7'h14;
    localparam logic [OUT_W-1:0] DIV_125M = 7'h10;
    localparam logic [OUT_W-1:0] DIV_133M = 7'h0F;

    // Control and disable reset values
    localparam logic CTRL_MARGIN_RST = 1'b0;
    localparam logic CTRL_SPREAD_RST = 1'b0;
    localparam logic [REF_OUTS-1:0] REF_DIS_RST = 2'h0;
    localparam logic [DDR_OUTS-1:0] DDR_DIS_RST = 4'h0;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

// >>> bit_sync.sv
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module bit_sync
#(
    parameter int unsigned WIDTH = 1
)
(
    input wire logic mclk_i,              // Core clock
    input wire logic rst_n_i,             // Async reset, active low
    input wire logic [WIDTH-1:0] async_i, // Pin levels
    output logic [WIDTH-1:0] sync_o       // Synchronised levels
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_bit
            always_ff @(posedge mclk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    meta_q[g] <= 1'b0;
                    sync_q[g] <= 1'b0;
                end
                else
                begin
                    meta_q[g] <= async_i[g];
                    sync_q[g] <= meta_q[g];
                end
            end
        end
    endgenerate

    assign sync_o = sync_q;

endmodule
`default_nettype wire

// >>> strap_decode.sv
// Strap code to default output divider decode
`timescale 1ns/1ps
`default_nettype none
module strap_decode
    import clk_cfg_pkg::*;
(
    input wire logic [STRAP_W-1:0] freq_strap_code_i, // Captured strap code
    output logic [OUT_W-1:0] sys_div_o,               // System clock divider default
    output logic [OUT_W-1:0] ddr_div_o                // DDR clock divider default
);

    function automatic logic [OUT_W-1:0] pick_div(input logic [1:0] sel);
        logic [OUT_W-1:0] d;
        d = DIV_66M;
        case (sel)
            2'h0: d = DIV_66M;
            2'h1: d = DIV_100M;
            2'h2: d = DIV_125M;
            2'h3: d = DIV_133M;
            default: d = DIV_66M;
        endcase
        return d;
    endfunction

    assign sys_div_o = pick_div(freq_strap_code_i[3:2]);
    assign ddr_div_o = pick_div(freq_strap_code_i[1:0]);

endmodule
`default_nettype wire

// >>> clk_div_cfg.sv
// Divider and output-enable configuration with AHB-Lite register access
`timescale 1ns/1ps
`default_nettype none
module clk_div_cfg
    import clk_cfg_pkg::*;
(
    input wire logic mclk_i,                         // Core clock, 250 MHz
    input wire logic rst_n_i,                        // Async reset, active low
    // AHB-Lite slave
    input wire logic hsel_i,                         // Slave select
    input wire logic [31:0] haddr_i,                 // Address
    input wire logic [1:0] htrans_i,                 // Transfer type
    input wire logic hwrite_i,                       // Write strobe
    input wire logic [2:0] hsize_i,                  // Transfer size
    input wire logic [31:0] hwdata_i,                // Write data
    input wire logic hready_i,                       // Bus ready
    output logic [31:0] hrdata_o,                    // Read data
    output logic hreadyout_o,                        // Slave ready
    output logic hresp_o,                            // Response, always OKAY
    // Pins
    input wire logic [STRAP_W-1:0] freq_strap_code_i, // Frequency strap pins
    input wire logic hard_reset_input_i,             // Hard reset pin, active high
    input wire logic ref_output_enable_pin_i,        // Reference outputs enable pin
    input wire logic ddr_output_enable_pin_i,        // DDR outputs enable pin
    // Configuration to the PLL
    output logic [FB_W-1:0] fb_div_o,                // Feedback divider
    output logic [OUT_W-1:0] sys_div_o,              // System clock output divider
    output logic [OUT_W-1:0] ddr_div_o,              // DDR clock output divider
    output logic spread_en_o,                        // Spread spectrum enable
    output logic [REF_OUTS-1:0] ref_out_en_o,        // Reference output enables
    output logic [DDR_OUTS-1:0] ddr_out_en_o         // DDR output enables
);

    // Pin synchronisation
    logic [STRAP_W+2:0] pins_sync;
    logic [STRAP_W-1:0] strap_sync;
    logic hard_rst_sync;
    logic ref_pin_sync;
    logic ddr_pin_sync;

    bit_sync #(.WIDTH(STRAP_W + 3)) u_pin_sync (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .async_i({ddr_output_enable_pin_i, ref_output_enable_pin_i,
                  hard_reset_input_i, freq_strap_code_i}),
        .sync_o(pins_sync)
    );

    assign strap_sync = pins_sync[STRAP_W-1:0];
    assign hard_rst_sync = pins_sync[STRAP_W];
    assign ref_pin_sync = pins_sync[STRAP_W+1];
    assign ddr_pin_sync = pins_sync[STRAP_W+2];

    // Strap load sequencing
    logic [1:0] settle_q;
    logic [1:0] settle_d;
    logic powered_q;
    logic load;
    logic [STRAP_W-1:0] strap_q;
    logic [OUT_W-1:0] sys_def;
    logic [OUT_W-1:0] ddr_def;
    logic [OUT_W-1:0] sys_load;
    logic [OUT_W-1:0] ddr_load;

    // Wait for the synchronisers to fill before the power-up load
    assign settle_d = (settle_q == 2'(STRAP_SETTLE_CYC)) ? settle_q : settle_q + 2'h1;
    // Loading repeats while the hard reset pin is held, so release leaves the last sample
    assign load = (!powered_q && settle_q == 2'(STRAP_SETTLE_CYC)) || hard_rst_sync;

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            settle_q <= 2'h0;
            powered_q <= 1'b0;
        end
        else
        begin
            settle_q <= settle_d;
            powered_q <= powered_q || (settle_q == 2'(STRAP_SETTLE_CYC));
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            strap_q <= '0;
        else if (load)
            strap_q <= strap_sync;
    end

    // Defaults follow the strap code captured at the last load
    strap_decode u_strap_decode (
        .freq_strap_code_i(strap_q),
        .sys_div_o(sys_def),
        .ddr_div_o(ddr_def)
    );

    // The load edge decodes the straps it captures, so no stale default slips through
    strap_decode u_load_decode (
        .freq_strap_code_i(strap_sync),
        .sys_div_o(sys_load),
        .ddr_div_o(ddr_load)
    );

    // AHB-Lite address phase capture
    logic addr_ok;
    logic wr_q;
    logic rd_q;
    logic [7:0] addr_q;
    logic rd_wait_q;

    // SEQ is taken like NONSEQ; hsize is not decoded since every register is one whole word
    assign addr_ok = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ || htrans_i == 2'h3);

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= 8'h00;
        end
        else if (hready_i)
        begin
            wr_q <= addr_ok && hwrite_i;
            rd_q <= addr_ok && !hwrite_i;
            addr_q <= haddr_i[7:0];
        end
    end

    // Reads take one wait state so that read data come from a flop
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rd_wait_q <= 1'b0;
        else
            rd_wait_q <= rd_q && !rd_wait_q;
    end

    assign hreadyout_o = !(rd_q && !rd_wait_q);
    assign hresp_o = 1'b0;

    // Write decode
    logic wr_ctrl;
    logic wr_fb;
    logic wr_out;
    logic wr_dis;

    assign wr_ctrl = wr_q && addr_q == CTRL_OFS;
    assign wr_fb = wr_q && addr_q == FB_DIV_OFS;
    assign wr_out = wr_q && addr_q == OUT_DIV_OFS;
    assign wr_dis = wr_q && addr_q == OUT_DIS_OFS;

    // Control register
    logic margin_q;
    logic spread_q;

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            margin_q <= CTRL_MARGIN_RST;
            spread_q <= CTRL_SPREAD_RST;
        end
        else if (load)
        begin
            margin_q <= CTRL_MARGIN_RST;
            spread_q <= CTRL_SPREAD_RST;
        end
        else if (wr_ctrl)
        begin
            margin_q <= hwdata_i[CTRL_MARGIN_BIT];
            spread_q <= hwdata_i[CTRL_SPREAD_BIT];
        end
    end

    // Divider registers
    logic fb_take;
    logic out_take;
    logic [FB_W-1:0] fb_q;
    logic [FB_W-1:0] fb_d;
    logic [OUT_W-1:0] sys_q;
    logic [OUT_W-1:0] sys_d;
    logic [OUT_W-1:0] ddr_q;
    logic [OUT_W-1:0] ddr_d;

    // Spread blocks only the feedback divider; output dividers stay programmable
    assign fb_take = wr_fb && margin_q && !spread_q;
    assign out_take = wr_out && margin_q;
    // The values written are used as raw ratios; even values 10..126 are the host's burden
    assign fb_d = !margin_q ? FB_DIV_DEF
                : fb_take ? hwdata_i[FB_W-1:0] : fb_q;
    assign sys_d = !margin_q ? sys_def
                 : out_take ? hwdata_i[SYS_DIV_LSB +: OUT_W] : sys_q;
    assign ddr_d = !margin_q ? ddr_def
                 : out_take ? hwdata_i[DDR_DIV_LSB +: OUT_W] : ddr_q;

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            fb_q <= FB_DIV_DEF;
            sys_q <= DIV_66M;
            ddr_q <= DIV_66M;
        end
        else if (load)
        begin
            fb_q <= FB_DIV_DEF;
            sys_q <= sys_load;
            ddr_q <= ddr_load;
        end
        else
        begin
            fb_q <= fb_d;
            sys_q <= sys_d;
            ddr_q <= ddr_d;
        end
    end

    // Output disable register
    logic [REF_OUTS-1:0] ref_dis_q;
    logic [DDR_OUTS-1:0] ddr_dis_q;

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ref_dis_q <= REF_DIS_RST;
            ddr_dis_q <= DDR_DIS_RST;
        end
        else if (load)
        begin
            ref_dis_q <= REF_DIS_RST;
            ddr_dis_q <= DDR_DIS_RST;
        end
        else if (wr_dis)
        begin
            // Taken in any margin or spread state
            ref_dis_q <= hwdata_i[REF_DIS_LSB +: REF_OUTS];
            ddr_dis_q <= hwdata_i[DDR_DIS_LSB +: DDR_OUTS];
        end
    end

    // Output enables: pin low wins, software can only remove an output
    logic [REF_OUTS-1:0] ref_en_d;
    logic [DDR_OUTS-1:0] ddr_en_d;
    logic [REF_OUTS-1:0] ref_en_q;
    logic [DDR_OUTS-1:0] ddr_en_q;

    assign ref_en_d = {REF_OUTS{ref_pin_sync}} & ~ref_dis_q;
    assign ddr_en_d = {DDR_OUTS{ddr_pin_sync}} & ~ddr_dis_q;

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ref_en_q <= '0;
            ddr_en_q <= '0;
        end
        else
        begin
            ref_en_q <= ref_en_d;
            ddr_en_q <= ddr_en_d;
        end
    end

    // Read mux
    logic [31:0] rd_mux;
    logic [31:0] status_word;
    logic [31:0] hrdata_q;

    // Margin counts as active only with spread off
    assign status_word = {21'h0, margin_q && !spread_q, ddr_en_q, ref_en_q, strap_q};
    assign rd_mux = (addr_q == CTRL_OFS) ? {30'h0, spread_q, margin_q}
                  : (addr_q == FB_DIV_OFS) ? {21'h0, fb_q}
                  : (addr_q == OUT_DIV_OFS) ? {17'h0, ddr_q, 1'b0, sys_q}
                  : (addr_q == OUT_DIS_OFS) ? {26'h0, ddr_dis_q, ref_dis_q}
                  : (addr_q == STATUS_OFS) ? status_word
                  : 32'h0;

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            hrdata_q <= 32'h0;
        else if (rd_q && !rd_wait_q)
            hrdata_q <= rd_mux;
    end

    assign hrdata_o = hrdata_q;

    // PLL-facing outputs come straight from flops
    assign fb_div_o = fb_q;
    assign sys_div_o = sys_q;
    assign ddr_div_o = ddr_q;
    assign spread_en_o = spread_q;
    assign ref_out_en_o = ref_en_q;
    assign ddr_out_en_o = ddr_en_q;

endmodule
`default_nettype wire

// >>> clk_div_cfg_assertions.sv
// Port-level checks for the divider configuration block
`timescale 1ns/1ps
`default_nettype none
module clk_div_cfg_checker
    import clk_cfg_pkg::*;
(
    input wire logic mclk_i, // Core clock
    input wire logic rst_n_i, // Async reset
    input wire logic hsel_i, // Select
    input wire logic [1:0] htrans_i, // Transfer type
    input wire logic hwrite_i, // Write
    input wire logic hready_i, // Bus ready
    input wire logic [31:0] hrdata_o, // Read data
    input wire logic hreadyout_o, // Slave ready
    input wire logic hresp_o, // Response
    input wire logic hard_reset_input_i, // Hard reset pin
    input wire logic ref_output_enable_pin_i, // Ref pin
    input wire logic ddr_output_enable_pin_i, // DDR pin
    input wire logic [FB_W-1:0] fb_div_o, // Feedback divider
    input wire logic spread_en_o, // Spread
    input wire logic [REF_OUTS-1:0] ref_out_en_o, // Ref enables
    input wire logic [DDR_OUTS-1:0] ddr_out_en_o // DDR enables
);
    logic wr_dph_q;
    logic [3:0] hr_q;
    wire logic take_w = hsel_i && hready_i && htrans_i[1];
    // Pin history is loose on purpose: the reload follows the pin through a synchroniser
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_dph_q <= 1'b0;
            hr_q <= 4'h0;
        end
        else
        begin
            wr_dph_q <= take_w && hwrite_i;
            hr_q <= {hr_q[2:0], hard_reset_input_i};
        end
    end
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence s_rd_wait;
        !hreadyout_o ##1 hreadyout_o;
    endsequence
    a_read_one_wait: assert property (take_w && !hwrite_i |=> s_rd_wait)
        else $error("read does not take exactly one wait state");
    a_write_zero_wait: assert property (take_w && hwrite_i |=> hreadyout_o)
        else $error("write data phase stalled");
    a_resp_okay: assert property (hresp_o == 1'b0)
        else $error("response not OKAY");
    a_ref_pin_off: assert property (!ref_output_enable_pin_i [*3] |=> ref_out_en_o == '0)
        else $error("reference output enabled while its pin disables it");
    a_ddr_pin_gate: assert property (|ddr_out_en_o |-> $past(ddr_output_enable_pin_i, 3))
        else $error("DDR output enabled without its pin");
    a_fb_change_cause: assert property ($changed(fb_div_o) |-> $past(wr_dph_q) ||
        $past(wr_dph_q, 2) || |hr_q)
        else $error("feedback divider changed without a write or reload");
    a_spread_change_cause: assert property ($changed(spread_en_o) |->
        $past(wr_dph_q) || |hr_q)
        else $error("spread bit changed without a write or reload");
    a_rdata_hold: assert property ($changed(hrdata_o) |-> $past(hreadyout_o) == 1'b0 || |hr_q)
        else $error("read data changed outside a read");
endmodule
bind clk_div_cfg clk_div_cfg_checker clk_div_cfg_checker_i (.mclk_i, .rst_n_i, .hsel_i,
    .htrans_i, .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .hard_reset_input_i,
    .ref_output_enable_pin_i, .ddr_output_enable_pin_i, .fb_div_o, .spread_en_o,
    .ref_out_en_o, .ddr_out_en_o);
`default_nettype wire

// >>> ahb_host_model.sv
// Bus master model of the host that programs the divider registers
`timescale 1ns/1ps
`default_nettype none
module ahb_host_model
    import clk_cfg_pkg::*;
(
    input wire logic mclk_i, // Core clock
    input wire logic hready_i, // Bus ready
    input wire logic [31:0] hrdata_i, // Read data
    output logic hsel_o, // Select, always on
    output logic [31:0] haddr_o, // Address
    output logic [1:0] htrans_o, // Transfer type
    output logic hwrite_o, // Write
    output logic [2:0] hsize_o, // Word size
    output logic [31:0] hwdata_o // Write data
);
    initial
    begin
        hsel_o = 1'b1;
        haddr_o = 32'h0;
        htrans_o = 2'h0;
        hwrite_o = 1'b0;
        hsize_o = 3'h2;
        hwdata_o = 32'h0;
    end
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge mclk_i);
        while (hready_i !== 1'b1)
        begin
            n++;
            if (n > 50)
            begin
                tb.err_count++;
                tb.results();
            end
            @(posedge mclk_i);
        end
    endtask
    // Released lines are inverted so a stale value is never mistaken for live data
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge mclk_i);
        haddr_o <= {24'h0, a};
        htrans_o <= HTRANS_NONSEQ;
        hwrite_o <= w;
        hwdata_o <= ~hwdata_o;
        wait_rdy();
        htrans_o <= 2'h0;
        haddr_o <= ~haddr_o;
        hwdata_o <= w ? d : ~hwdata_o;
        wait_rdy();
        r = hrdata_i;
        hwdata_o <= ~hwdata_o;
    endtask
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the divider configuration block
`timescale 1ns/1ps
`default_nettype none
module tb
    import clk_cfg_pkg::*;
;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [STRAP_W-1:0] freq_strap_code_i = 4'h6;
    logic hard_reset_input_i = 1'b0;
    logic ref_output_enable_pin_i = 1'b1;
    logic ddr_output_enable_pin_i = 1'b1;
    logic hsel_i, hwrite_i, hreadyout_o, hresp_o, spread_en_o;
    logic [1:0] htrans_i;
    logic [2:0] hsize_i;
    logic [31:0] haddr_i, hwdata_i, hrdata_o;
    logic [FB_W-1:0] fb_div_o;
    logic [OUT_W-1:0] sys_div_o, ddr_div_o;
    logic [REF_OUTS-1:0] ref_out_en_o;
    logic [DDR_OUTS-1:0] ddr_out_en_o;
    int err_count = 0;
    int tests_run = 0;
    clk_div_cfg clk_div_cfg_i (.mclk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
        .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
        .freq_strap_code_i, .hard_reset_input_i, .ref_output_enable_pin_i,
        .ddr_output_enable_pin_i, .fb_div_o, .sys_div_o, .ddr_div_o, .spread_en_o,
        .ref_out_en_o, .ddr_out_en_o);
    ahb_host_model host_i (.mclk_i, .hready_i(hreadyout_o), .hrdata_i(hrdata_o),
        .hsel_o(hsel_i), .haddr_o(haddr_i), .htrans_o(htrans_i), .hwrite_o(hwrite_i),
        .hsize_o(hsize_i), .hwdata_o(hwdata_i));
    always #2 mclk_i = ~mclk_i;
    task automatic results;
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic pause(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        host_i.xfer(1'b1, a, d, r);
    endtask
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        host_i.xfer(1'b0, a, 32'h0, r);
        chk(name, r, exp);
    endtask
    task automatic chk_div(input logic [FB_W-1:0] f, input logic [OUT_W-1:0] s,
        input logic [OUT_W-1:0] d);
        chk("fb_div", 32'(fb_div_o), 32'(f));
        chk("sys_div", 32'(sys_div_o), 32'(s));
        chk("ddr_div", 32'(ddr_div_o), 32'(d));
    endtask
    // Pin held long enough for the synchroniser to pass the new straps through
    task automatic hreset(input logic [STRAP_W-1:0] s);
        @(posedge mclk_i);
        freq_strap_code_i <= s;
        hard_reset_input_i <= 1'b1;
        pause(4);
        @(posedge mclk_i);
        hard_reset_input_i <= 1'b0;
        pause(4);
    endtask
    function automatic logic [OUT_W-1:0] dflt(input logic [1:0] s);
        case (s)
            2'h0: return DIV_66M;
            2'h1: return DIV_100M;
            2'h2: return DIV_125M;
            default: return DIV_133M;
        endcase
    endfunction
    initial
    begin
        repeat (3) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        pause(8);
        chk_div(FB_DIV_DEF, DIV_100M, DIV_125M);
        chk("sys_mhz", REF_MHZ * 32'(fb_div_o) / (PRESCALE * 32'(sys_div_o)), 32'h64);
        chk("ddr_mhz", REF_MHZ * 32'(fb_div_o) / (PRESCALE * 32'(ddr_div_o)), 32'h7D);
        rd_chk("status", STATUS_OFS, 32'h0000_03F6);
        rd_chk("ctrl", CTRL_OFS, 32'h0);
        rd_chk("out_dis", OUT_DIS_OFS, 32'h0);
        wr(8'h20, 32'hFFFF_FFFF);
        rd_chk("unmapped", 8'h20, 32'h0);
        for (int i = 0; i < 16; i++)
        begin
            hreset(4'(i));
            chk_div(FB_DIV_DEF, dflt(2'(i >> 2)), dflt(2'(i)));
        end
        wr(FB_DIV_OFS, 32'h0000_0060);
        wr(OUT_DIV_OFS, 32'h0000_0A0A);
        pause(3);
        chk_div(FB_DIV_DEF, DIV_133M, DIV_133M);
        wr(CTRL_OFS, 32'h1);
        wr(FB_DIV_OFS, 32'h0000_07FF);
        wr(OUT_DIV_OFS, 32'h0000_7E0A);
        pause(2);
        chk_div(11'h7FF, 7'h0A, 7'h7E);
        rd_chk("status", STATUS_OFS, 32'h0000_07FF);
        wr(OUT_DIV_OFS, 32'h0000_1010);
        pause(2);
        chk_div(11'h7FF, 7'h10, 7'h10);
        wr(CTRL_OFS, 32'h3);
        wr(FB_DIV_OFS, 32'h0000_0100);
        wr(OUT_DIV_OFS, 32'h0000_0C7E);
        pause(2);
        chk_div(11'h7FF, 7'h7E, 7'h0C);
        chk("spread", 32'(spread_en_o), 32'h1);
        rd_chk("status", STATUS_OFS, 32'h0000_03FF);
        rd_chk("ctrl", CTRL_OFS, 32'h3);
        wr(OUT_DIS_OFS, 32'h0000_0005);
        pause(4);
        chk("ref_en", 32'(ref_out_en_o), 32'h2);
        chk("ddr_en", 32'(ddr_out_en_o), 32'hE);
        @(posedge mclk_i);
        ref_output_enable_pin_i <= 1'b0;
        ddr_output_enable_pin_i <= 1'b0;
        wr(OUT_DIS_OFS, 32'h0);
        pause(4);
        chk("ref_en", 32'(ref_out_en_o), 32'h0);
        chk("ddr_en", 32'(ddr_out_en_o), 32'h0);
        @(posedge mclk_i);
        ref_output_enable_pin_i <= 1'b1;
        ddr_output_enable_pin_i <= 1'b1;
        pause(4);
        chk("ref_en", 32'(ref_out_en_o), 32'h3);
        chk("ddr_en", 32'(ddr_out_en_o), 32'hF);
        hreset(4'h9);
        rd_chk("ctrl", CTRL_OFS, 32'h0);
        chk_div(FB_DIV_DEF, DIV_125M, DIV_100M);
        wr(CTRL_OFS, 32'h1);
        wr(FB_DIV_OFS, 32'h0000_00AA);
        wr(CTRL_OFS, 32'h0);
        pause(3);
        chk_div(FB_DIV_DEF, DIV_125M, DIV_100M);
        results();
    end
endmodule
`default_nettype wire
